// File: core/tx_timestamp_one_step_update.sv
`timescale 1ns/100ps
`include "tsu_defs.svh"

module tx_timestamp_one_step_update
  import tsu_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic single_pass_update_enable,
  input wire logic [29:0] tx_clock_ns,
  input wire logic [31:0] link_delay_ns,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic tx_frame_flag,
  input wire logic [15:0] tx_frame_tag,
  input wire logic [29:0] tx_ingress_time_ns,
  output logic [7:0] tx_data_r,
  output logic tx_valid_r,
  output logic tx_first_r,
  output logic tx_last_r,
  input wire logic tx_ready,
  output logic [31:0] tx_time_capture_reg,
  output logic time_capture_ready,
  input wire logic time_capture_clear
);

  // ----------------------------------------
  // ones-complement helpers
  // ----------------------------------------
  function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

  function automatic logic [15:0] oc_sum4(input logic [63:0] v);
    return oc_add(oc_add(v[63:48], v[47:32]), oc_add(v[31:16], v[15:0]));
  endfunction

  // ----------------------------------------
  // input buffer
  // ----------------------------------------
  tsu_word_t in_word;
  tsu_word_t f_word;
  logic f_valid;
  logic f_ready;
  logic fifo_in_ready;

  assign in_word = '{data: in_data, sop: in_sop, eop: in_eop, flag: tx_frame_flag,
                     tag: tx_frame_tag, ingress: tx_ingress_time_ns};
  assign in_ready = fifo_in_ready;

  tsu_fifo #(.W(`TSU_WORD_W), .D(`TSU_FIFO_DEPTH), .AW(`TSU_FIFO_AW)) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(in_valid),
    .in_ready(fifo_in_ready),
    .in_data(in_word),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_word)
  );

  // ----------------------------------------
  // state and frame control
  // ----------------------------------------
  tsu_state_t st_r;
  logic [63:0] sr_r;
  logic [3:0] fill_r;
  logic [10:0] idx_r;
  logic [1:0] fcs_cnt_r;
  logic first_r;
  logic upd_r;
  logic ovw_r;
  logic udp_r;
  logic link_r;
  logic [7:0] off_r;
  logic [29:0] txts_r;
  logic [29:0] ingress_r;
  logic [15:0] comp_r;
  logic udp_armed_r;
  logic [31:0] cap_r;
  logic cap_rdy_r;
  logic [31:0] crc;

  wire adv = !tx_valid_r || tx_ready;
  wire st_idle = (st_r == TSU_IDLE);
  wire st_frame = (st_r == TSU_FRAME);
  wire st_flush = (st_r == TSU_FLUSH);
  wire st_fcs = (st_r == TSU_FCS);
  assign f_ready = adv && (st_idle || st_frame);
  wire pop = f_valid && f_ready;
  wire sop_take = pop && st_idle && f_word.sop;
  wire take = sop_take || (pop && st_frame);
  wire fill_full = (fill_r == `TSU_FILL_FULL);

  wire upd_req = single_pass_update_enable && f_word.flag && !f_word.tag[`TSU_TAG_OVW]
                 && f_word.tag[`TSU_TAG_UPD];
  wire ovw_req = single_pass_update_enable && f_word.flag && f_word.tag[`TSU_TAG_OVW];

  // field located by tag offset only
  wire hit = pop && st_frame && (idx_r == ({3'h0, off_r} + `TSU_FIELD_LAST));

  // ----------------------------------------
  // field arithmetic
  // ----------------------------------------
  // oldest byte lands in the top bits
  wire [63:0] shifted = {sr_r[55:0], f_word.data};
  wire [30:0] transit_raw = {1'b0, txts_r} - {1'b0, ingress_r};
  wire [29:0] transit = transit_raw[30] ? (transit_raw[29:0] + `TSU_NS_PER_SEC) : transit_raw[29:0];
  wire [47:0] delta = {18'h00000, transit} + (link_r ? {16'h0000, link_delay_ns} : 48'h000000000000);
  // correction plus transit (and link delay when link_r), scaled by two to the sixteen
  wire [63:0] corr_new = shifted + {delta, 16'h0000};
  wire [63:0] field_new = ovw_r ? {34'h000000000, txts_r} : (upd_r ? corr_new : shifted);
  // compensation word for the trailing pad
  wire [15:0] comp_nxt = oc_add(oc_sum4(shifted), ~oc_sum4(field_new));
  wire [63:0] loaded = hit ? field_new : shifted;
  wire pad_fix = f_word.eop && udp_armed_r;
  wire [63:0] sr_in = pad_fix ? {loaded[63:16], oc_add(loaded[15:0], comp_r)} : loaded;

  // ----------------------------------------
  // output selection
  // ----------------------------------------
  wire emit_data = (take && st_frame && fill_full) || (st_flush && adv && (fill_r != 4'h0));
  wire emit = emit_data || (st_fcs && adv);
  wire [31:0] fcs_word = ~crc;
  wire [7:0] fcs_byte = fcs_word[{fcs_cnt_r, 3'b000} +: 8];
  wire [7:0] emit_byte = st_fcs ? fcs_byte : sr_r[63:56];
  wire fcs_done = st_fcs && adv && (fcs_cnt_r == `TSU_FCS_LAST);

  // crc over the bytes as sent
  tsu_crc32 u_crc (
    .clk(clk),
    .reset(reset),
    .init(sop_take),
    .en(emit_data),
    .data(sr_r[63:56]),
    .crc(crc)
  );

  // ----------------------------------------
  // next values
  // ----------------------------------------
  wire [3:0] fill_inc = fill_full ? fill_r : (fill_r + 4'h1);
  wire [3:0] fill_nxt = sop_take ? 4'h1 : (take ? fill_inc : (emit_data ? (fill_r - 4'h1) : fill_r));
  wire [63:0] sr_nxt = take ? sr_in : (emit_data ? {sr_r[55:0], 8'h00} : sr_r);
  wire [10:0] idx_nxt = sop_take ? 11'h001 : ((take && idx_r != `TSU_IDX_MAX) ? (idx_r + 11'h001) : idx_r);
  wire to_flush = take && f_word.eop;
  wire flush_done = st_flush && adv && (fill_r <= 4'h1);
  tsu_state_t st_nxt;
  assign st_nxt = to_flush ? TSU_FLUSH : (sop_take ? TSU_FRAME : (flush_done ? TSU_FCS :
                  (fcs_done ? TSU_IDLE : st_r)));

  wire cap_set = sop_take && f_word.flag;
  wire cap_rdy_nxt = cap_set || (cap_rdy_r && !time_capture_clear);

  assign tx_time_capture_reg = cap_r;
  assign time_capture_ready = cap_rdy_r;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= TSU_IDLE;
      sr_r <= 64'h0000000000000000;
      fill_r <= 4'h0;
      idx_r <= 11'h000;
    end else begin
      st_r <= st_nxt;
      sr_r <= sr_nxt;
      fill_r <= fill_nxt;
      idx_r <= idx_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      upd_r <= 1'b0;
      ovw_r <= 1'b0;
      udp_r <= 1'b0;
      link_r <= 1'b0;
      off_r <= 8'h00;
      txts_r <= 30'h00000000;
      ingress_r <= 30'h00000000;
    end else if (sop_take) begin
      upd_r <= upd_req;
      ovw_r <= ovw_req;
      udp_r <= upd_req && f_word.tag[`TSU_TAG_UDP];
      link_r <= upd_req && f_word.tag[`TSU_TAG_LINK];
      off_r <= f_word.tag[`TSU_TAG_OFF_HI:`TSU_TAG_OFF_LO];
      txts_r <= tx_clock_ns;
      ingress_r <= f_word.ingress;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      comp_r <= 16'h0000;
      udp_armed_r <= 1'b0;
    end else if (sop_take) begin
      udp_armed_r <= 1'b0;
    end else if (hit) begin
      comp_r <= comp_nxt;
      udp_armed_r <= udp_r;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fcs_cnt_r <= 2'h0;
      first_r <= 1'b0;
    end else begin
      fcs_cnt_r <= st_fcs ? (adv ? fcs_cnt_r + 2'h1 : fcs_cnt_r) : 2'h0;
      first_r <= sop_take || (first_r && !emit_data);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
      tx_first_r <= 1'b0;
      tx_last_r <= 1'b0;
    end else if (adv) begin
      tx_valid_r <= emit;
      tx_data_r <= emit_byte;
      tx_first_r <= emit_data && first_r;
      tx_last_r <= fcs_done;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cap_r <= 32'h00000000;
      cap_rdy_r <= 1'b0;
    end else begin
      cap_r <= cap_set ? {2'b00, tx_clock_ns} : cap_r;
      cap_rdy_r <= cap_rdy_nxt;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  cap_write_a: assert property (@(posedge clk) disable iff (reset)
    cap_set |=> tx_time_capture_reg == {2'b00, $past(tx_clock_ns)}) else $error("capture value wrong");

  ready_set_a: assert property (@(posedge clk) disable iff (reset)
    cap_set |=> time_capture_ready ##1 (time_capture_ready || $past(time_capture_clear)))
    else $error("ready bit not set");

  unflag_hold_a: assert property (@(posedge clk) disable iff (reset)
    sop_take && !f_word.flag && !time_capture_clear |=> $stable(tx_time_capture_reg)
    && time_capture_ready == $past(time_capture_ready)) else $error("unflagged frame disturbed capture");

  cap_width_a: assert property (@(posedge clk) disable iff (reset)
    tx_time_capture_reg[31:30] == 2'b00) else $error("capture top bits set");

  select_a: assert property (@(posedge clk) disable iff (reset)
    sop_take && (!single_pass_update_enable || f_word.tag[`TSU_TAG_OVW]) |=> !upd_r)
    else $error("update selected wrongly");

  disabled_a: assert property (@(posedge clk) disable iff (reset)
    hit && !upd_r && !ovw_r && !pad_fix |=> sr_r == $past(shifted)) else $error("field changed while off");

  corr_add_a: assert property (@(posedge clk) disable iff (reset)
    hit && upd_r && !pad_fix |=> sr_r - $past(shifted) == {$past(delta), 16'h0000})
    else $error("correction sum wrong");

  transit_a: assert property (@(posedge clk) disable iff (reset)
    hit && upd_r && !link_r |-> delta < {18'h00000, `TSU_NS_PER_SEC}) else $error("transit beyond second");

  overwrite_a: assert property (@(posedge clk) disable iff (reset)
    hit && ovw_r && !pad_fix |=> sr_r == {34'h000000000, $past(txts_r)}) else $error("overwrite wrong");

  fcs_len_a: assert property (@(posedge clk) disable iff (reset)
    flush_done |-> ##[1:200] tx_last_r && tx_valid_r) else $error("fcs never ended");

endmodule // tx_timestamp_one_step_update

// File: core/tsu_defs.svh
`ifndef TSU_DEFS_SVH
`define TSU_DEFS_SVH

// ----------------------------------------
// frame tag fields
// ----------------------------------------
`define TSU_TAG_UPD 4
`define TSU_TAG_LINK 5
`define TSU_TAG_UDP 6
`define TSU_TAG_OFF_LO 7
`define TSU_TAG_OFF_HI 14
`define TSU_TAG_OVW 15

// ----------------------------------------
// widths, depths, reset values
// ----------------------------------------
`define TSU_WORD_W 57
`define TSU_FIFO_DEPTH 16
`define TSU_FIFO_AW 4
`define TSU_FIELD_LAST 11'h007
`define TSU_IDX_MAX 11'h7FF
`define TSU_FILL_FULL 4'h8
`define TSU_CRC_INIT 32'hFFFFFFFF
`define TSU_CRC_POLY 32'hEDB88320
`define TSU_FCS_LAST 2'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define TSU_NS_PER_SEC 30'h3B9ACA00

`endif

// File: core/tsu_pkg.sv
package tsu_pkg;

  // one byte of the fabric stream with its frame sideband
  typedef struct packed {
    logic [7:0] data;
    logic sop;
    logic eop;
    logic flag;
    logic [15:0] tag;
    logic [29:0] ingress;
  } tsu_word_t;

  typedef enum logic [1:0] {
    TSU_IDLE = 2'b00,
    TSU_FRAME = 2'b01,
    TSU_FLUSH = 2'b11,
    TSU_FCS = 2'b10
  } tsu_state_t;

endpackage

// File: core/tsu_fifo.sv
`timescale 1ns/100ps
`include "tsu_defs.svh"

module tsu_fifo #(
  parameter int W = `TSU_WORD_W,
  parameter int D = `TSU_FIFO_DEPTH,
  parameter int AW = `TSU_FIFO_AW
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] mem_r [D];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic room_r;
  wire full = !room_r;
  wire empty = (wr_r == rd_r);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  wire [AW:0] wr_nxt = push ? (wr_r + 1'b1) : wr_r;
  wire [AW:0] rd_nxt = pop ? (rd_r + 1'b1) : rd_r;
  // registered so the ready output is a plain flop
  wire room_nxt = !((wr_nxt[AW] != rd_nxt[AW]) && (wr_nxt[AW-1:0] == rd_nxt[AW-1:0]));

  assign in_ready = room_r;
  assign out_valid = !empty;
  assign out_data = mem_r[rd_r[AW-1:0]];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_r <= '0;
      rd_r <= '0;
      room_r <= 1'b1;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      room_r <= room_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem_r[wr_r[AW-1:0]] <= in_data;
  end

  fifo_full_a: assert property (@(posedge clk) disable iff (reset)
    full |-> !in_ready && (wr_r - rd_r) == (AW+1)'(D)) else $error("fifo full count wrong");

endmodule // tsu_fifo

// File: core/tsu_crc32.sv
`timescale 1ns/100ps
`include "tsu_defs.svh"

module tsu_crc32 (
  input wire logic clk,
  input wire logic reset,
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [31:0] crc
);

  // reflected ethernet crc, one byte per step
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `TSU_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  logic [31:0] crc_r;
  wire [31:0] crc_nxt = init ? `TSU_CRC_INIT : (en ? crc_step(crc_r, data) : crc_r);
  assign crc = crc_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) crc_r <= `TSU_CRC_INIT;
    else crc_r <= crc_nxt;
  end

endmodule // tsu_crc32

// File: tb/tsu_fabric_model.sv
`timescale 1ns/100ps

module tsu_fabric_model (
  input wire logic clk,
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_sop,
  output logic in_eop,
  output logic tx_frame_flag,
  output logic [15:0] tx_frame_tag,
  output logic [29:0] tx_ingress_time_ns
);
  logic [7:0] frame_mem [0:63];

  initial begin
    in_valid = 1'b0;
    in_data = 8'h00;
    in_sop = 1'b0;
    in_eop = 1'b0;
    tx_frame_flag = 1'b0;
    tx_frame_tag = 16'h0000;
    tx_ingress_time_ns = 30'h0;
  end

  // ----------------------------------------
  // frame writer
  // ----------------------------------------
  // tag chosen per frame by caller
  task automatic send_frame(input int len, input logic flg, input logic [15:0] tg, input logic [29:0] ing);
    int i;
    i = 0;
    while (i < len) begin
      in_valid <= 1'b1;
      in_data <= frame_mem[i];
      in_sop <= (i == 0);
      in_eop <= (i == len - 1);
      // sideband valid with first byte only
      tx_frame_flag <= (i == 0) ? flg : ~flg;
      tx_frame_tag <= (i == 0) ? tg : ~tg;
      tx_ingress_time_ns <= (i == 0) ? ing : ~ing;
      @(posedge clk);
      if (in_ready) begin
        i++;
      end
    end
  endtask

  // released data line shows the inverse of its last value
  task automatic idle();
    in_valid <= 1'b0;
    in_data <= ~in_data;
    in_sop <= 1'b0;
    in_eop <= 1'b0;
    @(posedge clk);
  endtask
endmodule // tsu_fabric_model

// File: tb/tx_timestamp_one_step_update_tb.sv
`timescale 1ns/100ps
`include "tsu_defs.svh"

module tx_timestamp_one_step_update_tb;
  logic clk, reset, single_pass_update_enable, in_valid, in_ready, in_sop, in_eop, tx_frame_flag;
  logic tx_valid_r, tx_first_r, tx_last_r, tx_ready, time_capture_ready, time_capture_clear;
  logic [7:0] in_data, tx_data_r;
  logic [15:0] tx_frame_tag;
  logic [29:0] tx_clock_ns, tx_ingress_time_ns, cap_exp;
  logic [31:0] link_delay_ns, tx_time_capture_reg;
  logic [1:0] cyc;
  logic [7:0] got [$];
  int fail_count, n_compared, stall, out_len;

  tx_timestamp_one_step_update dut (
    .clk(clk), .reset(reset), .single_pass_update_enable(single_pass_update_enable),
    .tx_clock_ns(tx_clock_ns), .link_delay_ns(link_delay_ns), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .in_sop(in_sop), .in_eop(in_eop), .tx_frame_flag(tx_frame_flag),
    .tx_frame_tag(tx_frame_tag), .tx_ingress_time_ns(tx_ingress_time_ns), .tx_data_r(tx_data_r),
    .tx_valid_r(tx_valid_r), .tx_first_r(tx_first_r), .tx_last_r(tx_last_r), .tx_ready(tx_ready),
    .tx_time_capture_reg(tx_time_capture_reg), .time_capture_ready(time_capture_ready),
    .time_capture_clear(time_capture_clear)
  );

  tsu_fabric_model fab (
    .clk(clk), .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data), .in_sop(in_sop), .in_eop(in_eop),
    .tx_frame_flag(tx_frame_flag), .tx_frame_tag(tx_frame_tag), .tx_ingress_time_ns(tx_ingress_time_ns)
  );

  always #20 clk = ~clk;

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      fail_count++;
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic logic [15:0] sum16(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int k = 0; k < 8; k++) r = r[0] ? ((r >> 1) ^ `TSU_CRC_POLY) : (r >> 1);
    return r;
  endfunction

  // ----------------------------------------
  // downstream sink, stalls on demand
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 2'h1;
    tx_ready <= (stall == 0) || (stall == 1 && cyc == 2'h0);
    if (tx_valid_r === 1'b1 && tx_ready === 1'b1) begin
      check("first", tx_first_r, got.size() % out_len == 0);
      check("last", tx_last_r, got.size() % out_len == out_len - 1);
      got.push_back(tx_data_r);
    end
  end

  // ----------------------------------------
  // one frame, sent reps times back to back
  // ----------------------------------------
  task automatic run(input string name, input int len, input logic flg, input logic [15:0] tg,
    input logic [29:0] ing, input logic [29:0] txt, input logic [31:0] lnk, input logic en,
    input int reps, input int st);
    logic [7:0] e [0:63];
    logic [63:0] corr;
    logic [31:0] crc;
    longint tr;
    int off;
    int n;
    logic [15:0] s0;
    logic [15:0] s1;
    off = int'(tg[14:7]);
    for (int i = 0; i < len; i++) begin
      e[i] = 8'(i * 37 + 5);
      fab.frame_mem[i] = e[i];
    end
    // update only for flagged, enabled frames holding the field
    if (flg && en && len >= off + 8) begin
      corr = 64'h0;
      for (int i = 0; i < 8; i++) corr = {corr[55:0], e[off + i]};
      tr = longint'(txt) - longint'(ing);
      if (tr < 0) tr += `TSU_NS_PER_SEC;
      if (tg[15]) corr = {34'h0, txt};
      else if (tg[4]) corr += 64'((tr + longint'(tg[5] ? lnk : 32'h0)) << 16);
      for (int i = 0; i < 8; i++) e[off + i] = corr[63 - 8 * i -: 8];
    end
    // last payload word keeps the ones-complement sum
    if (flg && en && len > off + 8 && tg[6] && tg[4] && !tg[15]) begin
      s0 = 16'h0000;
      s1 = 16'h0000;
      for (int i = 0; i < len; i += 2) s0 = sum16(s0, {fab.frame_mem[i], fab.frame_mem[i + 1]});
      for (int i = 0; i < len - 2; i += 2) s1 = sum16(s1, {e[i], e[i + 1]});
      {e[len - 2], e[len - 1]} = sum16(s0, ~s1);
    end
    crc = `TSU_CRC_INIT;
    for (int i = 0; i < len; i++) crc = crc_step(crc, e[i]);
    crc = ~crc;
    got.delete();
    out_len = len + 4;
    stall <= st;
    single_pass_update_enable <= en;
    tx_clock_ns <= txt;
    link_delay_ns <= lnk;
    @(posedge clk);
    fork
      begin
        for (int r = 0; r < reps; r++) fab.send_frame(len, flg, tg, ing);
        fab.idle();
      end
    join_none
    if (st == 2) begin
      n = 0;
      while (in_ready !== 1'b0 && n < 200) begin
        @(posedge clk);
        n++;
      end
      check("fifo refuses", in_ready, 1'b0);
      stall <= 1;
    end
    n = 0;
    while (got.size() < reps * out_len && n < 4000) begin
      @(posedge clk);
      n++;
    end
    check("byte count", got.size(), reps * out_len);
    for (int i = 0; i < reps * out_len; i++) begin
      check("byte", got[i], (i % out_len < len) ? e[i % out_len] : crc[8 * (i % out_len - len) +: 8]);
    end
    check("fifo drained", in_ready, 1'b1);
    if (flg) begin
      cap_exp = txt;
    end
    check("capture", tx_time_capture_reg, {2'b00, cap_exp});
    check("ready", time_capture_ready, flg);
    time_capture_clear <= 1'b1;
    @(posedge clk);
    time_capture_clear <= 1'b0;
    repeat (2) @(posedge clk);
    check("ready cleared", time_capture_ready, 1'b0);
    $display("test %s done", name);
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    cyc = 2'h0;
    tx_ready = 1'b1;
    stall = 0;
    out_len = 1;
    cap_exp = 30'h0;
    single_pass_update_enable = 1'b0;
    tx_clock_ns = 30'h0;
    link_delay_ns = 32'h0;
    time_capture_clear = 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("ready at reset", time_capture_ready, 1'b0);
    check("capture at reset", tx_time_capture_reg, 32'h0);
    check("in_ready at reset", in_ready, 1'b1);
    check("valid at reset", tx_valid_r, 1'b0);
    run("plain", 40, 1'b0, 16'h0000, 30'h0, 30'h100, 32'h0, 1'b1, 1, 0);
    run("unflagged", 40, 1'b0, 16'h0B10, 30'h3E8, 30'h1388, 32'h0, 1'b1, 1, 0);
    run("disabled", 40, 1'b1, 16'h0B10, 30'h3E8, 30'h1388, 32'h0, 1'b0, 1, 0);
    run("e2e", 40, 1'b1, 16'h0B10, 30'h3E8, 30'h1388, 32'h0, 1'b1, 1, 0);
    run("p2p", 40, 1'b1, 16'h0B30, 30'h3E8, 30'h1388, 32'h12C, 1'b1, 1, 0);
    run("wrap", 40, 1'b1, 16'h0B10, 30'h3B9AC618, 30'h7D0, 32'h0, 1'b1, 1, 0);
    run("overwrite", 40, 1'b1, 16'h8B00, 30'h3E8, 30'h2345, 32'h0, 1'b1, 1, 0);
    run("too short", 40, 1'b1, 16'h1090, 30'h3E8, 30'h1388, 32'h0, 1'b1, 1, 0);
    run("udp", 40, 1'b1, 16'h0B50, 30'h3E8, 30'h1388, 32'h0, 1'b1, 1, 0);
    run("back2back", 40, 1'b1, 16'h0F10, 30'h3E8, 30'h1388, 32'h0, 1'b1, 2, 1);
    run("fifo fill", 40, 1'b1, 16'h0B10, 30'h64, 30'h5000, 32'h0, 1'b1, 1, 2);
    tally_and_finish();
  end

  // ----------------------------------------
  // hang guard
  // ----------------------------------------
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    $display("ERROR watchdog expected finish seen hang");
    tally_and_finish();
  end
endmodule // tx_timestamp_one_step_update_tb
